// [include/optbyte_pkg.sv]
// Purpose: constants for the option byte configuration decoder
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: option byte offsets and bit positions are local choices
package optbyte_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_READOUT = 8'h00;
    localparam logic [7:0] ADDR_BOOT = 8'h04;
    localparam logic [7:0] ADDR_RSVD = 8'h08;
    localparam logic [7:0] ADDR_WDOG = 8'h0c;
    localparam logic [7:0] ADDR_OSC = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // readout protection disable pattern
    localparam logic [7:0] READOUT_OPEN = 8'haa;
    // boot code area codes
    localparam logic [7:0] BOOT_NONE = 8'h00;
    localparam logic [7:0] BOOT_VECT = 8'h01;
    localparam logic [7:0] BOOT_TWO = 8'h02;
    localparam logic [7:0] BOOT_THREE = 8'h03;
    localparam logic [7:0] BOOT_MAX = 8'hff;
    localparam logic [7:0] LAST_PAGE_MAX = 8'hfe;
    // watchdog option byte field positions
    localparam int WD_IND_HW = 0;
    localparam int WD_IND_HALT = 1;
    localparam int WD_WIN_HW = 2;
    localparam int WD_WIN_HALT = 3;
    // oscillator settle byte field positions
    localparam int OSC_FAST_LSB = 0;
    localparam int OSC_SLOW_LSB = 2;
    // settle counts per code
    localparam logic [12:0] SETTLE_C0 = 13'h0001;
    localparam logic [12:0] SETTLE_C1 = 13'h0010;
    localparam logic [12:0] SETTLE_C2 = 13'h0200;
    localparam logic [12:0] SETTLE_C3 = 13'h1000;
    // reset values of the option bytes
    localparam logic [7:0] RST_READOUT = 8'h00;
    localparam logic [7:0] RST_BOOT = 8'h00;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [7:0] RST_OSC = 8'h00;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // settle cycle count for a two-bit code
    function automatic logic [12:0] settle_cycles(input logic [1:0] code);
        case (code)
            2'b00: settle_cycles = SETTLE_C0;
            2'b01: settle_cycles = SETTLE_C1;
            2'b10: settle_cycles = SETTLE_C2;
            default: settle_cycles = SETTLE_C3;
        endcase
    endfunction
endpackage

// [core/osc_settle.sv]
// Purpose: counts oscillator ticks until the oscillator counts as stable
// Assumes: osc_tick is a one-cycle pulse per oscillator cycle, synchronous to clk
// Notes: restarts whenever enable drops
`timescale 1ns/1ps
module osc_settle (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic enable,
    input wire logic [1:0] code,
    input wire logic osc_tick,
    // result
    output logic stable
);
    logic [12:0] count_r;

    // count oscillator ticks until the selected number is reached
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            count_r <= 13'h0000;
        end else if (osc_tick && !stable) begin
            count_r <= count_r + 13'h0001;
        end
    end

    // stable once the count reaches the selected number
    assign stable = enable && (count_r >= optbyte_pkg::settle_cycles(code));
endmodule

// [core/boot_area_decode.sv]
// Purpose: turns the boot code size byte into a protected page range
// Assumes: page numbers are eight bits
// Notes: combinational
`timescale 1ns/1ps
module boot_area_decode (
    // input code
    input wire logic [7:0] size_code,
    // decoded area
    output logic area_valid,
    output logic vectors_only,
    output logic [7:0] last_page,
    output logic read_protect,
    output logic write_protect
);
    // map the size code to the reserved page range and its protection
    always_comb begin
        area_valid = 1'b1;
        vectors_only = 1'b0;
        last_page = 8'h00;
        read_protect = 1'b0;
        write_protect = 1'b1;
        if (size_code == optbyte_pkg::BOOT_NONE) begin
            area_valid = 1'b0;
            write_protect = 1'b0;
        end else if (size_code == optbyte_pkg::BOOT_VECT) begin
            vectors_only = 1'b1;
            write_protect = 1'b0;
        end else if (size_code == optbyte_pkg::BOOT_TWO) begin
            last_page = 8'h01;
            read_protect = 1'b1;
        end else if (size_code == optbyte_pkg::BOOT_MAX) begin
            last_page = optbyte_pkg::LAST_PAGE_MAX;
        end else begin
            last_page = size_code - 8'h01;
        end
    end
endmodule

// [core/option_byte_config_decoder.sv]
// Purpose: holds option bytes and decodes them for protection, watchdog and clock units
// Assumes: AXI4-Lite slave, synchronous active-high reset, 40 MHz clock
// Notes: single clock domain, one read and one write at a time
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module option_byte_config_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // system events
    input wire logic halt_mode,
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    input wire logic fast_osc_on,
    input wire logic slow_osc_on,
    // memory protection
    output logic readout_protected,
    output logic boot_area_valid,
    output logic boot_vectors_only,
    output logic [7:0] boot_last_page,
    output logic boot_read_protect,
    output logic boot_write_protect,
    // watchdogs
    output logic indep_watchdog_run,
    output logic indep_watchdog_halt_stop,
    output logic window_watchdog_run,
    output logic window_watchdog_halted,
    output logic window_watchdog_halt_rst,
    // clocks
    output logic fast_osc_ready,
    output logic slow_osc_ready
);
    // write and read channel state
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    // option bytes
    logic [7:0] readout_protect_byte_r;
    logic [7:0] boot_code_size_byte_r;
    logic [7:0] watchdog_option_byte_r;
    logic [7:0] oscillator_settle_byte_r;
    // software control, halt pulse, write handshake, settle status and decoded fields
    logic indep_sw_start_r;
    logic window_sw_start_r;
    logic halt_q_r;
    logic win_halt_rst_r;
    logic write_go;
    logic write_ok;
    logic fast_stable;
    logic slow_stable;
    logic [7:0] readout_protect_code;
    logic [7:0] boot_code_area_size;
    logic indep_watchdog_hw_start;
    logic window_watchdog_hw_start;
    logic window_watchdog_halt_reset;
    logic [1:0] fast_osc_settle_count;
    logic [1:0] slow_osc_settle_count;

    // address is mapped and writable
    function automatic logic is_writable(input logic [7:0] a);
        is_writable = (a == optbyte_pkg::ADDR_READOUT) || (a == optbyte_pkg::ADDR_BOOT)
            || (a == optbyte_pkg::ADDR_WDOG) || (a == optbyte_pkg::ADDR_OSC)
            || (a == optbyte_pkg::ADDR_CTRL) || (a == optbyte_pkg::ADDR_RSVD);
    endfunction

    // field extraction
    assign readout_protect_code = readout_protect_byte_r;
    assign boot_code_area_size = boot_code_size_byte_r;
    assign indep_watchdog_hw_start = watchdog_option_byte_r[optbyte_pkg::WD_IND_HW];
    assign indep_watchdog_halt_stop = watchdog_option_byte_r[optbyte_pkg::WD_IND_HALT];
    assign window_watchdog_hw_start = watchdog_option_byte_r[optbyte_pkg::WD_WIN_HW];
    assign window_watchdog_halt_reset = watchdog_option_byte_r[optbyte_pkg::WD_WIN_HALT];
    assign fast_osc_settle_count = oscillator_settle_byte_r[optbyte_pkg::OSC_FAST_LSB +: 2];
    assign slow_osc_settle_count = oscillator_settle_byte_r[optbyte_pkg::OSC_SLOW_LSB +: 2];

    // write address and data are taken independently, in either order
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign write_go = aw_held_r && w_held_r && !bvalid_r;
    assign write_ok = write_go && is_writable(aw_addr_r);

    // capture write address
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (write_go) begin
            aw_held_r <= 1'b0;
        end
    end

    // capture write data
    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (write_go) begin
            w_held_r <= 1'b0;
        end
    end

    // write response after both halves arrive
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= optbyte_pkg::RESP_OKAY;
        end else if (write_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= write_ok ? optbyte_pkg::RESP_OKAY : optbyte_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // option byte storage, lane 0 only; the reserved byte is not stored
    always_ff @(posedge clk) begin
        if (rst) begin
            readout_protect_byte_r <= optbyte_pkg::RST_READOUT;
            boot_code_size_byte_r <= optbyte_pkg::RST_BOOT;
            watchdog_option_byte_r <= optbyte_pkg::RST_WDOG;
            oscillator_settle_byte_r <= optbyte_pkg::RST_OSC;
        end else if (write_ok && w_strb_r[0]) begin
            if (aw_addr_r == optbyte_pkg::ADDR_READOUT) begin
                readout_protect_byte_r <= w_data_r[7:0];
            end else if (aw_addr_r == optbyte_pkg::ADDR_BOOT) begin
                boot_code_size_byte_r <= w_data_r[7:0];
            end else if (aw_addr_r == optbyte_pkg::ADDR_WDOG) begin
                watchdog_option_byte_r <= w_data_r[7:0];
            end else if (aw_addr_r == optbyte_pkg::ADDR_OSC) begin
                oscillator_settle_byte_r <= w_data_r[7:0];
            end
        end
    end

    // software start bits: once set they stay until reset
    always_ff @(posedge clk) begin
        if (rst) begin
            indep_sw_start_r <= 1'b0;
            window_sw_start_r <= 1'b0;
        end else if (write_ok && w_strb_r[0] && aw_addr_r == optbyte_pkg::ADDR_CTRL) begin
            indep_sw_start_r <= indep_sw_start_r | w_data_r[0];
            window_sw_start_r <= window_sw_start_r | w_data_r[1];
        end
    end

    // readout protection decode
    assign readout_protected = (readout_protect_code != optbyte_pkg::READOUT_OPEN);

    // boot code area decode
    boot_area_decode u_boot (
        .size_code(boot_code_area_size),
        .area_valid(boot_area_valid),
        .vectors_only(boot_vectors_only),
        .last_page(boot_last_page),
        .read_protect(boot_read_protect),
        .write_protect(boot_write_protect)
    );

    // watchdog activation
    assign indep_watchdog_run = indep_watchdog_hw_start || indep_sw_start_r;
    assign window_watchdog_run = window_watchdog_hw_start || window_sw_start_r;
    assign window_watchdog_halted = window_watchdog_run && halt_mode && !window_watchdog_halt_reset;

    // one-cycle reset request on entry into halt
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_q_r <= 1'b0;
            win_halt_rst_r <= 1'b0;
        end else begin
            halt_q_r <= halt_mode;
            win_halt_rst_r <= window_watchdog_run && window_watchdog_halt_reset
                && halt_mode && !halt_q_r;
        end
    end
    assign window_watchdog_halt_rst = win_halt_rst_r;

    // oscillator settle counters
    osc_settle u_fast (
        .clk(clk),
        .rst(rst),
        .enable(fast_osc_on),
        .code(fast_osc_settle_count),
        .osc_tick(fast_osc_tick),
        .stable(fast_stable)
    );
    osc_settle u_slow (
        .clk(clk),
        .rst(rst),
        .enable(slow_osc_on),
        .code(slow_osc_settle_count),
        .osc_tick(slow_osc_tick),
        .stable(slow_stable)
    );
    assign fast_osc_ready = fast_stable;
    assign slow_osc_ready = slow_stable;

    // read channel, one cycle latency
    assign s_axi_arready = !rvalid_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= optbyte_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= optbyte_pkg::RESP_OKAY;
            if (s_axi_araddr == optbyte_pkg::ADDR_READOUT) begin
                rdata_r <= {24'h000000, readout_protect_byte_r};
            end else if (s_axi_araddr == optbyte_pkg::ADDR_BOOT) begin
                rdata_r <= {24'h000000, boot_code_size_byte_r};
            end else if (s_axi_araddr == optbyte_pkg::ADDR_RSVD) begin
                rdata_r <= 32'h0000_0000;
            end else if (s_axi_araddr == optbyte_pkg::ADDR_WDOG) begin
                rdata_r <= {24'h000000, watchdog_option_byte_r};
            end else if (s_axi_araddr == optbyte_pkg::ADDR_OSC) begin
                rdata_r <= {24'h000000, oscillator_settle_byte_r};
            end else if (s_axi_araddr == optbyte_pkg::ADDR_CTRL) begin
                rdata_r <= {30'h0, window_sw_start_r, indep_sw_start_r};
            end else if (s_axi_araddr == optbyte_pkg::ADDR_STATUS) begin
                rdata_r <= {24'h000000, boot_last_page} << 8 | {26'h0, slow_stable, fast_stable,
                    window_watchdog_run, indep_watchdog_run, boot_area_valid, readout_protected};
            end else begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= optbyte_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule

// [verification/option_byte_config_decoder_asserts.sv]
// Purpose: concurrent checks on the option byte decoder ports
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached by bind from the testbench top
`timescale 1ns/1ps
module option_byte_config_decoder_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // memory protection
    input wire logic boot_area_valid,
    input wire logic boot_vectors_only,
    input wire logic [7:0] boot_last_page,
    input wire logic boot_read_protect,
    input wire logic boot_write_protect,
    // watchdog and clocks
    input wire logic halt_mode,
    input wire logic window_watchdog_run,
    input wire logic window_watchdog_halted,
    input wire logic window_watchdog_halt_rst,
    input wire logic fast_osc_on,
    input wire logic slow_osc_on,
    input wire logic fast_osc_ready,
    input wire logic slow_osc_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // read data follows one cycle after the address is taken
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer not one cycle after address");
    // answers stand until taken
    property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped or changed");
    property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped or changed");
    // no boot area means no protection at all
    property p_boot_off;
        !boot_area_valid |-> !boot_vectors_only && !boot_read_protect && !boot_write_protect;
    endproperty
    a_boot_off: assert property (p_boot_off) else $error("protection without boot area");
    property p_vect; boot_vectors_only |-> boot_area_valid && !boot_read_protect && !boot_write_protect; endproperty
    a_vect: assert property (p_vect) else $error("vector-only area wrongly protected");
    // read protection only for the two-page area, which is also write protected
    property p_rd_prot; boot_read_protect |-> boot_write_protect && boot_last_page == 8'h01; endproperty
    a_rd_prot: assert property (p_rd_prot) else $error("read protection on wrong area");
    // halt reset is one pulse right after halt entry with the watchdog running
    property p_halt_rst;
        window_watchdog_halt_rst |-> ($past(halt_mode) && window_watchdog_run) ##1 !window_watchdog_halt_rst;
    endproperty
    a_halt_rst: assert property (p_halt_rst) else $error("halt reset pulse without cause");
    property p_halted; window_watchdog_halted |-> halt_mode && window_watchdog_run && !window_watchdog_halt_rst; endproperty
    a_halted: assert property (p_halted) else $error("window watchdog stopped without halt");
    // a disabled oscillator loses its settle count
    property p_fast_off; !fast_osc_on |=> !fast_osc_ready; endproperty
    a_fast_off: assert property (p_fast_off) else $error("fast oscillator ready while off");
    property p_slow_off; !slow_osc_on |=> !slow_osc_ready; endproperty
    a_slow_off: assert property (p_slow_off) else $error("slow oscillator ready while off");
endmodule

// [verification/option_byte_config_decoder_tb_top.sv]
// Purpose: self-checking bench for the option byte decoder
// Assumes: bus answers come whenever the slave is ready, ticks held high count once per cycle
// Notes: byte model kept in mdl, expected outputs computed from the written codes
`timescale 1ns/1ps
module option_byte_config_decoder_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, c, mdl [0:7];
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, halt_mode = 1'b0, tick = 1'b0, osc_on = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, readout_protected;
    logic boot_area_valid, boot_vectors_only, boot_read_protect, boot_write_protect, fast_osc_ready;
    logic [7:0] boot_last_page;
    logic indep_watchdog_run, indep_watchdog_halt_stop, window_watchdog_run, window_watchdog_halted;
    logic window_watchdog_halt_rst, slow_osc_ready;
    logic [7:0] codes [0:4] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hff};
    int err_total = 0, n_compared = 0, n;
    integer seed = 32'hc328;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    option_byte_config_decoder i_option_byte_config_decoder (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .halt_mode, .fast_osc_tick(tick), .slow_osc_tick(tick), .fast_osc_on(osc_on),
        .slow_osc_on(osc_on), .readout_protected, .boot_area_valid, .boot_vectors_only, .boot_last_page,
        .boot_read_protect, .boot_write_protect, .indep_watchdog_run, .indep_watchdog_halt_stop,
        .window_watchdog_run, .window_watchdog_halted, .window_watchdog_halt_rst, .fast_osc_ready,
        .slow_osc_ready);

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // counts, verdict and end of run
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // bus read; ready sampled at the falling edge is the value seen at the next rising edge
    task automatic axi_read(input logic [7:0] a, input logic [31:0] e);
        logic arh, rh;
        logic [31:0] d;
        logic [1:0] rsp;
        int t;
        t = 0;
        rh = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!rh) begin
            @(negedge clk);
            arh = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            if (arh) s_axi_arvalid <= 1'b0;
            if (t == 1) s_axi_rready <= 1'b1;
            if (rh) s_axi_rready <= 1'b0;
            t++;
        end
        check(d, (a <= 8'h10 && a != 8'h08) ? {24'h0, mdl[a[4:2]]} : e);
        check({30'h0, rsp}, {30'h0, (a > 8'h18) ? optbyte_pkg::RESP_SLVERR : optbyte_pkg::RESP_OKAY});
    endtask

    // bus write then read back, except at the control and status places
    task automatic access(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        logic [1:0] rsp;
        int t;
        t = 0;
        bh = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        while (!bh) begin
            @(negedge clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (t == 2) s_axi_bready <= 1'b1;
            if (bh) s_axi_bready <= 1'b0;
            t++;
        end
        check({30'h0, rsp}, {30'h0, (a > 8'h14) ? optbyte_pkg::RESP_SLVERR : optbyte_pkg::RESP_OKAY});
        if (a < 8'h14 && a != 8'h08) mdl[a[4:2]] = d[7:0];
        if (a != 8'h14 && a != 8'h18) axi_read(a, 32'h0);
    endtask

    // m oscillator ticks, one per cycle; ends at a falling edge where outputs are settled
    task automatic ticks(input int m);
        @(posedge clk);
        if (m > 0) begin
            tick <= 1'b1;
            repeat (m) @(posedge clk);
            tick <= 1'b0;
        end
        @(negedge clk);
    endtask

    // main sequence
    initial begin
        for (int i = 0; i < 8; i++) mdl[i] = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) axi_read(8'(i * 4), 32'h0);
        check(readout_protected, 1'b1);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'h000000aa : $random(seed);
            access(optbyte_pkg::ADDR_READOUT, v);
            check(readout_protected, v[7:0] != 8'haa);
        end
        // documented boot codes, then random ones
        for (int i = 0; i < 8; i++) begin
            c = (i < 5) ? codes[i] : 8'($random(seed));
            access(optbyte_pkg::ADDR_BOOT, {24'($random(seed)), c});
            check(boot_area_valid, c != 8'h00);
            check(boot_vectors_only, c == 8'h01);
            check(boot_read_protect, c == 8'h02);
            check(boot_write_protect, c >= 8'h02);
            if (c >= 8'h02) check(boot_last_page, c - 8'h01);
        end
        // every watchdog bit combination
        for (int i = 0; i < 16; i++) begin
            access(optbyte_pkg::ADDR_WDOG, 32'(i));
            check(indep_watchdog_run, i[0]);
            check(indep_watchdog_halt_stop, i[1]);
            check(window_watchdog_run, i[2]);
        end
        // halt entry with reset option set, then with stop option
        @(posedge clk);
        halt_mode <= 1'b1;
        @(posedge clk);
        #1;
        check(window_watchdog_halt_rst, 1'b1);
        @(posedge clk);
        #1;
        check({window_watchdog_halt_rst, window_watchdog_halted}, 2'b00);
        access(optbyte_pkg::ADDR_WDOG, 32'h4);
        check({window_watchdog_halt_rst, window_watchdog_halted}, 2'b01);
        halt_mode <= 1'b0;
        // software start once hardware start is off
        access(optbyte_pkg::ADDR_WDOG, 32'h0);
        check({indep_watchdog_run, window_watchdog_run}, 2'b00);
        access(optbyte_pkg::ADDR_CTRL, 32'h3);
        check({indep_watchdog_run, window_watchdog_run}, 2'b11);
        axi_read(optbyte_pkg::ADDR_CTRL, 32'h3);
        // settle counts per code, fast field first and slow field next; the other field holds code 0
        for (int j = 0; j < 8; j++) begin
            @(posedge clk);
            osc_on <= 1'b0;
            access(optbyte_pkg::ADDR_OSC, (j < 4) ? 32'(j % 4) : 32'((j % 4) * 4));
            @(posedge clk);
            osc_on <= 1'b1;
            n = (j % 4 == 0) ? 1 : (j % 4 == 1) ? 16 : (j % 4 == 2) ? 512 : 4096;
            ticks(n - 1);
            check({fast_osc_ready, slow_osc_ready}, (j < 4) ? {1'b0, n > 1} : {n > 1, 1'b0});
            ticks(1);
            check({fast_osc_ready, slow_osc_ready}, 2'b11);
        end
        // reserved, read-only and unmapped places
        access(optbyte_pkg::ADDR_RSVD, $random(seed));
        access(optbyte_pkg::ADDR_STATUS, $random(seed));
        access(8'h40, $random(seed));
        // mid-run reset restores option bytes and clears software starts
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) mdl[i] = 8'h00;
        axi_read(optbyte_pkg::ADDR_CTRL, 32'h0);
        axi_read(optbyte_pkg::ADDR_STATUS, 32'h1);
        check({indep_watchdog_run, window_watchdog_run, readout_protected}, 3'b001);
        complete_run;
    end

    // hang guard, well beyond the expected run length
    initial begin
        #600000;
        err_total++;
        complete_run;
    end
endmodule

bind option_byte_config_decoder option_byte_config_decoder_asserts i_option_byte_config_decoder_asserts (.clk, .rst,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .boot_area_valid, .boot_vectors_only, .boot_last_page, .boot_read_protect, .boot_write_protect,
    .halt_mode, .window_watchdog_run, .window_watchdog_halted, .window_watchdog_halt_rst, .fast_osc_on,
    .slow_osc_on, .fast_osc_ready, .slow_osc_ready);
